// ---- src/spr_pkg.sv ----
/*
 spr_pkg: constants, types and helper functions of the setpoint relay control block.
 Assumes a 20 MHz clock and 16-bit linear pressure codes from the measurement chain.
*/
package spr_pkg;
	localparam int CLOCK_HZ = 20_000_000;
	localparam int CYC_PER_MS = CLOCK_HZ / 1000;
	localparam int SHOW_TIME_MS = 5000;
	localparam int SAVE_TIME_MS = 5000;
	localparam int FINE_WINDOW_MS = 1000;
	localparam int REV_MIN_MS = 2000;
	localparam int REV_MAX_MS = 3000;
	localparam int STEP_TIME_MS = 100;
	localparam int ZERO_TIME_MS = 5000;
	localparam int SHOW_CYC = SHOW_TIME_MS * CYC_PER_MS;
	localparam int SAVE_CYC = SAVE_TIME_MS * CYC_PER_MS;
	localparam int FINE_CYC = FINE_WINDOW_MS * CYC_PER_MS;
	localparam int REV_MIN_CYC = REV_MIN_MS * CYC_PER_MS;
	localparam int REV_MAX_CYC = REV_MAX_MS * CYC_PER_MS;
	localparam int STEP_CYC = STEP_TIME_MS * CYC_PER_MS;
	localparam int ZERO_CYC = ZERO_TIME_MS * CYC_PER_MS;
	localparam int TMR_W = 27;
	localparam logic [15:0] RANGE_MIN = 16'h0000;
	localparam logic [15:0] RANGE_MAX = 16'hffff;
	localparam logic [15:0] STEP_COARSE = 16'h0100;
	localparam logic [15:0] STEP_FINE = 16'h0010;
	localparam logic [7:0] HYS_DEFAULT = 8'h0a;
	localparam logic [23:0] HYS_PERCENT = 24'h000064;
	localparam logic [15:0] FACTOR_DEFAULT = 16'h0100;
	localparam int FACTOR_FRAC = 8;
	localparam logic [7:0] OFS_CH_ONE = 8'h00;
	localparam logic [7:0] OFS_CH_TWO = 8'h20;
	localparam logic [7:0] OFS_STATUS = 8'h40;
	localparam logic [7:0] OFS_CMD = 8'h44;
	localparam logic [7:0] OFS_ATM = 8'h48;
	localparam logic [4:0] REG_CTRL = 5'h00;
	localparam logic [4:0] REG_LOW_THR = 5'h04;
	localparam logic [4:0] REG_HIGH_THR = 5'h08;
	localparam logic [4:0] REG_LOW_HYS = 5'h0c;
	localparam logic [4:0] REG_HIGH_HYS = 5'h10;
	localparam logic [4:0] REG_FACTOR = 5'h14;
	localparam int CTRL_LOW_EN = 0;
	localparam int CTRL_HIGH_EN = 1;
	localparam int CTRL_ATM = 2;
	localparam int CMD_ATM_ADJ = 0;
	localparam int ST_RELAY = 0;
	localparam int ST_ZERO = 2;
	localparam int ST_EDIT = 3;

	typedef struct packed {
		logic lowEn;
		logic highEn;
		logic atmMode;
		logic [15:0] lowThr;
		logic [15:0] highThr;
		logic [7:0] lowHys;
		logic [7:0] highHys;
		logic [15:0] factor;
	} spr_chan_cfg_type;

	localparam spr_chan_cfg_type CFG_RESET = '{lowEn: 1'b1, highEn: 1'b0, atmMode: 1'b0,
		lowThr: RANGE_MIN, highThr: RANGE_MIN, lowHys: HYS_DEFAULT, highHys: HYS_DEFAULT,
		factor: FACTOR_DEFAULT};

	typedef struct packed {
		logic setpointChannelOne;
		logic setpointChannelTwo;
		logic zeroAdjustButton;
	} spr_buttons_type;

	typedef enum {BTN_IDLE, BTN_SHOW, BTN_STEP, BTN_WAIT} spr_btn_state_type;

	function automatic logic [15:0] spr_hys_band(input logic [15:0] thr, input logic [7:0] hys);
		logic [23:0] prod;
		prod = thr * hys;
		return 16'(prod / HYS_PERCENT);
	endfunction : spr_hys_band

	function automatic logic [15:0] spr_scale_atm(input logic [15:0] fac, input logic [15:0] atmosphere_relative_setpoint);
		logic [31:0] prod;
		prod = (fac * atmosphere_relative_setpoint) >> FACTOR_FRAC;
		return (prod[31:16] != 16'h0000) ? RANGE_MAX : prod[15:0];
	endfunction : spr_scale_atm

	function automatic logic [15:0] spr_step(input logic [15:0] thr, input logic [15:0] inc,
		input logic up);
		logic [16:0] s;
		s = up ? {1'b0, thr} + {1'b0, inc} : {1'b0, thr} - {1'b0, inc};
		if (up) return (s[16] || s[15:0] > RANGE_MAX) ? RANGE_MAX : s[15:0];
		return (s[16] || s[15:0] < RANGE_MIN) ? RANGE_MIN : s[15:0];
	endfunction : spr_step

	function automatic logic [15:0] spr_merge16(input logic [15:0] old, input logic [15:0] wd,
		input logic [1:0] be);
		return {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
	endfunction : spr_merge16
endpackage : spr_pkg

// ---- src/spr_setpoint_relay.sv ----
/*
 spr_setpoint_relay: two hysteretic setpoint channels, push-button threshold editing,
 atmosphere-relative thresholds, zero-adjust timing and an Avalon-MM register slave.
 Assumes synchronous button levels (debounced outside) and a persistent store that
 takes a channel's configuration on its save strobe.
*/
`timescale 1ns/1ps
module spr_setpoint_relay #(
	parameter int SHOW_CYCLES = spr_pkg::SHOW_CYC,
	parameter int SAVE_CYCLES = spr_pkg::SAVE_CYC,
	parameter int FINE_CYCLES = spr_pkg::FINE_CYC,
	parameter int REV_MIN_CYCLES = spr_pkg::REV_MIN_CYC,
	parameter int REV_MAX_CYCLES = spr_pkg::REV_MAX_CYC,
	parameter int STEP_CYCLES = spr_pkg::STEP_CYC,
	parameter int ZERO_CYCLES = spr_pkg::ZERO_CYC
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// avalon-mm slave
	input wire logic [7:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	// measurement and buttons
	input wire logic [15:0] pressure,
	input wire logic [15:0] atmPressure,
	input wire spr_pkg::spr_buttons_type buttons,
	// outputs
	output logic [1:0] relay,
	output logic [1:0] indicator,
	output logic [1:0] symbolBlink,
	output logic [15:0] analogValue,
	output logic [1:0] saveStrobe,
	output logic zeroAdjustActive
);
	import spr_pkg::*;

	localparam int TW = TMR_W;

	spr_chan_cfg_type cfg [2];
	spr_btn_state_type st [2];
	logic [TW-1:0] tmr [2];
	logic [TW-1:0] zeroCnt;
	logic [1:0] fine, dirUp, btn, btnPrev, pressEdge, stepNow, editHigh;
	logic [1:0] lowState, highState, next_low, next_high;
	logic [15:0] effLow [2], effHigh [2], shown [2];
	logic [15:0] atmOffset, atmCorr;
	logic [31:0] rdMux;
	logic ack, busWr, zeroPrev;

	assign btn = {buttons.setpointChannelTwo, buttons.setpointChannelOne};
	assign pressEdge = btn & ~btnPrev;
	assign indicator = relay;
	assign atmCorr = 16'(atmPressure + atmOffset);

	// one wait state per access keeps the read mux off the bus critical path
	assign waitrequest = (read | write) & ~ack;
	assign busWr = write & ~waitrequest;

	always_ff @(posedge clock) begin : busAck
		if (rst) begin
			ack <= 1'b0;
		end else begin
			ack <= (read | write) & ~ack;
		end
	end

	function automatic logic chanHit(input logic [7:0] a, input int c);
		return a[7:6] == 2'b00 && a[5] == c[0];
	endfunction : chanHit

	always_comb begin : readMux
		rdMux = '0;
		if (address == OFS_STATUS) begin
			rdMux[ST_RELAY +: 2] = relay;
			rdMux[ST_ZERO] = zeroAdjustActive;
			rdMux[ST_EDIT +: 2] = symbolBlink;
		end else if (address == OFS_ATM) begin
			rdMux[15:0] = atmCorr;
		end else if (address[7:6] == 2'b00) begin
			unique case (address[4:0])
				REG_CTRL: rdMux[2:0] = {cfg[address[5]].atmMode, cfg[address[5]].highEn,
					cfg[address[5]].lowEn};
				REG_LOW_THR: rdMux[15:0] = cfg[address[5]].lowThr;
				REG_HIGH_THR: rdMux[15:0] = cfg[address[5]].highThr;
				REG_LOW_HYS: rdMux[7:0] = cfg[address[5]].lowHys;
				REG_HIGH_HYS: rdMux[7:0] = cfg[address[5]].highHys;
				REG_FACTOR: rdMux[15:0] = cfg[address[5]].factor;
				default: rdMux = '0;
			endcase
		end
	end

	always_ff @(posedge clock) begin : readReg
		if (rst) begin
			readdata <= '0;
		end else if (read && !ack) begin
			readdata <= rdMux;
		end
	end

	// configuration: bus writes first, button effects after so they win the same cycle
	always_ff @(posedge clock) begin : cfgRegs
		if (rst) begin
			for (int c = 0; c < 2; c++) begin
				cfg[c] <= CFG_RESET;
			end
		end else begin
			for (int c = 0; c < 2; c++) begin
				if (busWr && chanHit(address, c)) begin
					unique case (address[4:0])
						REG_CTRL: if (byteenable[0]) begin
							cfg[c].lowEn <= writedata[CTRL_LOW_EN];
							cfg[c].highEn <= writedata[CTRL_HIGH_EN];
							cfg[c].atmMode <= writedata[CTRL_ATM];
						end
						REG_LOW_THR: cfg[c].lowThr <= spr_merge16(cfg[c].lowThr,
							writedata[15:0], byteenable[1:0]);
						REG_HIGH_THR: cfg[c].highThr <= spr_merge16(cfg[c].highThr,
							writedata[15:0], byteenable[1:0]);
						REG_LOW_HYS: if (byteenable[0]) cfg[c].lowHys <= writedata[7:0];
						REG_HIGH_HYS: if (byteenable[0]) cfg[c].highHys <= writedata[7:0];
						REG_FACTOR: cfg[c].factor <= spr_merge16(cfg[c].factor,
							writedata[15:0], byteenable[1:0]);
						default: ;
					endcase
				end
				if (pressEdge[c] && st[c] == BTN_IDLE && !cfg[c].atmMode) begin
					cfg[c].lowHys <= HYS_DEFAULT;
					cfg[c].highHys <= HYS_DEFAULT;
				end
				if (stepNow[c]) begin
					if (editHigh[c]) begin
						cfg[c].highThr <= spr_step(cfg[c].highThr,
							fine[c] ? STEP_FINE : STEP_COARSE, dirUp[c]);
					end else begin
						cfg[c].lowThr <= spr_step(cfg[c].lowThr,
							fine[c] ? STEP_FINE : STEP_COARSE, dirUp[c]);
					end
				end
			end
		end
	end

	always_comb begin : effective
		for (int c = 0; c < 2; c++) begin
			editHigh[c] = cfg[c].highEn && !cfg[c].lowEn;
			effLow[c] = cfg[c].atmMode ? spr_scale_atm(cfg[c].factor, atmCorr)
				: cfg[c].lowThr;
			effHigh[c] = cfg[c].atmMode ? spr_scale_atm(cfg[c].factor, atmCorr)
				: cfg[c].highThr;
			shown[c] = cfg[c].atmMode ? cfg[c].factor
				: (editHigh[c] ? cfg[c].highThr : cfg[c].lowThr);
			stepNow[c] = st[c] == BTN_STEP && btn[c] && !cfg[c].atmMode
				&& tmr[c] == TW'(STEP_CYCLES - 1);
		end
	end

	// each trip half keeps its own state so combined mode keeps both hystereses
	always_comb begin : tripEval
		for (int c = 0; c < 2; c++) begin
			next_low[c] = lowState[c];
			next_high[c] = highState[c];
			if (pressure < effLow[c]) begin
				next_low[c] = 1'b1;
			end else if ({1'b0, pressure} > {1'b0, effLow[c]}
				+ {1'b0, spr_hys_band(effLow[c], cfg[c].lowHys)}) begin
				next_low[c] = 1'b0;
			end
			if (pressure > effHigh[c]) begin
				next_high[c] = 1'b1;
			end else if ({1'b0, pressure} + {1'b0, spr_hys_band(effHigh[c], cfg[c].highHys)}
				< {1'b0, effHigh[c]}) begin
				next_high[c] = 1'b0;
			end
		end
	end

	always_ff @(posedge clock) begin : relayRegs
		if (rst) begin
			lowState <= '0;
			highState <= '0;
			relay <= '0;
		end else begin
			lowState <= next_low;
			highState <= next_high;
			for (int c = 0; c < 2; c++) begin
				relay[c] <= (cfg[c].lowEn & next_low[c]) | (cfg[c].highEn & next_high[c]);
			end
		end
	end

	always_ff @(posedge clock) begin : buttonFsm
		if (rst) begin
			btnPrev <= '0;
			fine <= '0;
			dirUp <= '1;
			saveStrobe <= '0;
			for (int c = 0; c < 2; c++) begin
				st[c] <= BTN_IDLE;
				tmr[c] <= '0;
			end
		end else begin
			btnPrev <= btn;
			for (int c = 0; c < 2; c++) begin
				saveStrobe[c] <= 1'b0;
				unique case (st[c])
					BTN_IDLE: begin
						tmr[c] <= '0;
						fine[c] <= 1'b0;
						dirUp[c] <= 1'b1;
						if (pressEdge[c]) st[c] <= BTN_SHOW;
					end
					BTN_SHOW: begin
						tmr[c] <= tmr[c] + 1'b1;
						if (!btn[c]) begin
							st[c] <= BTN_WAIT;
							tmr[c] <= '0;
						end else if (tmr[c] == TW'(SHOW_CYCLES - 1)) begin
							st[c] <= BTN_STEP;
							tmr[c] <= '0;
						end
					end
					BTN_STEP: begin
						tmr[c] <= tmr[c] + 1'b1;
						if (!btn[c]) begin
							st[c] <= BTN_WAIT;
							tmr[c] <= '0;
						end else if (tmr[c] == TW'(STEP_CYCLES - 1)) begin
							tmr[c] <= '0;
						end
					end
					BTN_WAIT: begin
						tmr[c] <= tmr[c] + 1'b1;
						if (pressEdge[c]) begin
							st[c] <= BTN_STEP;
							tmr[c] <= '0;
							if (tmr[c] < TW'(FINE_CYCLES)) begin
								fine[c] <= 1'b1;
							end else if (tmr[c] >= TW'(REV_MIN_CYCLES)
								&& tmr[c] < TW'(REV_MAX_CYCLES)) begin
								dirUp[c] <= ~dirUp[c];
							end
						end else if (tmr[c] == TW'(SAVE_CYCLES - 1)) begin
							st[c] <= BTN_IDLE;
							saveStrobe[c] <= 1'b1;
						end
					end
				endcase
			end
		end
	end

	always_ff @(posedge clock) begin : displayRegs
		if (rst) begin
			analogValue <= '0;
			symbolBlink <= '0;
		end else begin
			for (int c = 0; c < 2; c++) begin
				symbolBlink[c] <= st[c] != BTN_IDLE;
			end
			// channel one wins if both are active; the output is a single value
			if (st[0] != BTN_IDLE) analogValue <= shown[0];
			else if (st[1] != BTN_IDLE) analogValue <= shown[1];
			else analogValue <= pressure;
		end
	end

	always_ff @(posedge clock) begin : zeroAdjust
		if (rst) begin
			zeroPrev <= 1'b0;
			zeroAdjustActive <= 1'b0;
			zeroCnt <= '0;
		end else begin
			zeroPrev <= buttons.zeroAdjustButton;
			if (!zeroAdjustActive) begin
				zeroCnt <= '0;
				if (buttons.zeroAdjustButton && !zeroPrev) zeroAdjustActive <= 1'b1;
			end else if (zeroCnt == TW'(ZERO_CYCLES - 1)) begin
				zeroAdjustActive <= 1'b0;
			end else begin
				zeroCnt <= zeroCnt + 1'b1;
			end
		end
	end

	// the offset aligns the atmosphere sensor to the main sensor at the moment of the command
	always_ff @(posedge clock) begin : atmAdjust
		if (rst) begin
			atmOffset <= '0;
		end else if (busWr && address == OFS_CMD && byteenable[0] && writedata[CMD_ATM_ADJ]) begin
			atmOffset <= 16'(pressure - atmPressure);
		end
	end
	property p_lowTrip;
		@(posedge clock) disable iff (rst)
		cfg[0].lowEn && !cfg[0].highEn && pressure < effLow[0] |=> relay[0];
	endproperty
	a_lowTrip: assert property (p_lowTrip) else $error("low trip relay not energized");
	property p_highTrip;
		@(posedge clock) disable iff (rst)
		cfg[1].highEn && pressure > effHigh[1] |=> relay[1] && indicator[1];
	endproperty
	a_highTrip: assert property (p_highTrip) else $error("high trip relay not energized");
	property p_hold;
		@(posedge clock) disable iff (rst)
		lowState[0] && pressure >= effLow[0] && pressure <= effLow[0]
			+ spr_hys_band(effLow[0], cfg[0].lowHys) && !cfg[0].lowHys[7] |=> lowState[0];
	endproperty
	a_hold: assert property (p_hold) else $error("relay released inside hysteresis");
	property p_resetCfg;
		@(posedge clock) rst |=> cfg[0].lowEn && !cfg[0].highEn && cfg[1].lowThr == RANGE_MIN;
	endproperty
	a_resetCfg: assert property (p_resetCfg) else $error("reset configuration wrong");
	property p_showValue;
		@(posedge clock) disable iff (rst)
		st[0] != BTN_IDLE |=> analogValue == $past(shown[0]);
	endproperty
	a_showValue: assert property (p_showValue) else $error("threshold not shown");
	property p_save;
		@(posedge clock) disable iff (rst)
		st[1] == BTN_WAIT && !pressEdge[1] && tmr[1] == TW'(SAVE_CYCLES - 1)
			|=> saveStrobe[1] && st[1] == BTN_IDLE ##1 !saveStrobe[1];
	endproperty
	a_save: assert property (p_save) else $error("save after release missing");
	property p_zero;
		@(posedge clock) disable iff (rst)
		$rose(buttons.zeroAdjustButton) && !zeroAdjustActive |=> zeroAdjustActive[*8];
	endproperty
	a_zero: assert property (p_zero) else $error("zero adjust did not start");
	property p_atmLocked;
		@(posedge clock) disable iff (rst)
		cfg[1].atmMode && !busWr |=> $stable(cfg[1].lowThr) && $stable(cfg[1].highThr);
	endproperty
	a_atmLocked: assert property (p_atmLocked) else $error("button changed relative setpoint");
	property p_hysRestore;
		@(posedge clock) disable iff (rst)
		pressEdge[0] && st[0] == BTN_IDLE && !cfg[0].atmMode |=> cfg[0].lowHys == HYS_DEFAULT;
	endproperty
	a_hysRestore: assert property (p_hysRestore) else $error("hysteresis not restored");
endmodule : spr_setpoint_relay

// ---- test/spr_host_model.sv ----
/*
 spr_host_model: operator push buttons and register bus host for the relay control block.
 Assumes an Avalon-MM slave that ends every access by dropping waitrequest.
*/
`timescale 1ns/1ps
module spr_host_model (
	// clock
	input wire logic clock,
	// avalon-mm master
	output logic [7:0] address,
	output logic read,
	output logic write,
	output logic [31:0] writedata,
	output logic [3:0] byteenable,
	input wire logic [31:0] readdata,
	input wire logic waitrequest,
	// operator
	output spr_pkg::spr_buttons_type buttons
);
	import spr_pkg::*;
	initial begin
		address = 8'h00;
		read = 1'b0;
		write = 1'b0;
		writedata = 32'h00000000;
		byteenable = 4'h3;
		buttons = '0;
	end
	// the request stands until waitrequest is seen low at a rising edge, for at most 20 rising edges
	task automatic access(input logic rd, input logic [7:0] a, input logic [15:0] d,
		output logic [15:0] q, output logic ok);
		int n;
		@(posedge clock);
		address <= a;
		writedata <= {16'h0000, d};
		read <= rd;
		write <= !rd;
		ok = 1'b0;
		q = 16'h0000;
		for (n = 0; n < 20 && !ok; n++) begin
			@(posedge clock);
			if (waitrequest === 1'b0) begin
				ok = 1'b1;
				q = readdata[15:0];
			end
		end
		read <= 1'b0;
		write <= 1'b0;
	endtask : access
	// index 0 and 1 are the setpoint buttons, 2 the zero button
	task automatic press(input int b, input logic v);
		@(posedge clock);
		buttons[2 - b] <= v;
	endtask : press
endmodule : spr_host_model

// ---- test/spr_setpoint_relay_tb.sv ----
/*
 spr_setpoint_relay_tb: self-checking bench for the setpoint relay control block.
 Assumes shortened timing parameters and the host model on bus and buttons.
*/
`timescale 1ns/1ps
module spr_setpoint_relay_tb;
	import spr_pkg::*;
	localparam int SHOW = 20;
	localparam int SAVE = 40;
	localparam int ZERO = 30;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [7:0] address;
	logic read, write, waitrequest, zeroAdjustActive, ok;
	logic [31:0] writedata, readdata;
	logic [3:0] byteenable;
	logic [15:0] pressure = 16'h8000;
	logic [15:0] atmPressure = 16'h4000;
	spr_buttons_type buttons;
	logic [1:0] relay, indicator, symbolBlink, saveStrobe;
	logic [15:0] analogValue, q, v1, v2, v3;
	logic [15:0] cfgv [2][6];
	logic lowSt [2];
	logic highSt [2];
	logic [31:0] p;
	int miscompares = 0;
	int check_count = 0;
	int n;
	always #25 clock = ~clock;
	spr_setpoint_relay #(.SHOW_CYCLES(SHOW), .SAVE_CYCLES(SAVE), .FINE_CYCLES(5),
		.REV_MIN_CYCLES(10), .REV_MAX_CYCLES(15), .STEP_CYCLES(4), .ZERO_CYCLES(ZERO)) dut (
		.clock(clock), .rst(rst), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .pressure(pressure), .atmPressure(atmPressure),
		.buttons(buttons), .relay(relay), .indicator(indicator), .symbolBlink(symbolBlink),
		.analogValue(analogValue), .saveStrobe(saveStrobe),
		.zeroAdjustActive(zeroAdjustActive));
	spr_host_model host (.clock(clock), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .buttons(buttons));
	task automatic summarize;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : summarize
	task automatic chk(input logic [31:0] s, input logic [31:0] e, input string w);
		check_count++;
		if (s !== e) begin
			miscompares++;
			$display("BAD %0t %s seen %h expected %h", $time, w, s, e);
		end
	endtask : chk
	task automatic hang;
		miscompares++;
		$display("BAD %0t wait ran out", $time);
		summarize();
	endtask : hang
	task automatic acc(input logic rd, input logic [7:0] a, input logic [15:0] d);
		host.access(rd, a, d, q, ok);
		if (ok !== 1'b1) hang();
	endtask : acc
	// effective threshold; relative mode saturates at the range top
	function automatic logic [31:0] eff(input int c, input int hi);
		logic [31:0] m;
		m = (32'(cfgv[c][5]) * 32'(atmPressure)) >> 8;
		if (cfgv[c][0][2] === 1'b1) return (m > 32'h0000ffff) ? 32'h0000ffff : m;
		return 32'(cfgv[c][1 + hi]);
	endfunction : eff
	function automatic logic [31:0] band(input logic [31:0] t, input logic [15:0] h);
		return t * 32'(h) / 32'd100;
	endfunction : band
	function automatic logic expRelay(input int c);
		return (cfgv[c][0][0] & lowSt[c]) | (cfgv[c][0][1] & highSt[c]);
	endfunction : expRelay
	// both halves evolve every cycle, so the model follows each config step too
	task automatic refUpd;
		logic [31:0] lo, hi;
		for (int c = 0; c < 2; c++) begin
			lo = eff(c, 0);
			hi = eff(c, 1);
			if (32'(pressure) < lo) lowSt[c] = 1'b1;
			else if (32'(pressure) > lo + band(lo, cfgv[c][3])) lowSt[c] = 1'b0;
			if (32'(pressure) > hi) highSt[c] = 1'b1;
			else if (32'(pressure) + band(hi, cfgv[c][4]) < hi) highSt[c] = 1'b0;
		end
	endtask : refUpd
	task automatic wf(input int c, input int k, input logic [15:0] d);
		acc(1'b0, 8'(c * 32 + k * 4), d);
		cfgv[c][k] = d;
		repeat (2) @(posedge clock);
		refUpd();
	endtask : wf
	task automatic settle(input logic [15:0] pv);
		pressure <= pv;
		repeat (3) @(posedge clock);
		refUpd();
		chk({indicator, relay}, {expRelay(1), expRelay(0), expRelay(1), expRelay(0)}, "relay");
	endtask : settle
	task automatic waitSave(input int c);
		for (n = 0; n < SAVE + 20 && saveStrobe[c] !== 1'b1; n++) @(posedge clock);
		if (n == SAVE + 20) hang();
	endtask : waitSave
	initial begin
		for (int c = 0; c < 2; c++) begin
			cfgv[c] = '{16'h0001, 16'h0000, 16'h0000, 16'h000a, 16'h000a, 16'h0100};
			lowSt[c] = 1'b0;
			highSt[c] = 1'b0;
		end
		void'($urandom(32'hdd34f534));
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		chk({relay, indicator, symbolBlink, saveStrobe, zeroAdjustActive}, 0, "reset outs");
		for (int c = 0; c < 2; c++) begin
			for (int k = 0; k < 6; k++) begin
				acc(1'b1, 8'(c * 32 + k * 4), 16'h0000);
				chk(q, cfgv[c][k], "reset reg");
			end
		end
		acc(1'b1, 8'h60, 16'h0000);
		chk(q, 0, "unmapped");
		$display("test reset done");
		settle(16'($urandom));
		for (int r = 0; r < 3; r++) begin
			case (r)
				0: begin
					wf(0, 1, 16'($urandom_range(16'h0800, 16'hf000)));
					wf(1, 0, 16'h0002);
					wf(1, 2, 16'($urandom_range(16'h0800, 16'hf000)));
				end
				1: begin
					wf(0, 0, 16'h0003);
					wf(0, 2, 16'($urandom_range(16'h0800, 16'hf000)));
					wf(1, 0, 16'h0001);
					wf(1, 1, 16'($urandom_range(16'h0800, 16'hf000)));
					wf(1, 3, 16'h0014);
				end
				default: begin
					atmPressure <= 16'($urandom_range(16'h2000, 16'h9fff));
					wf(1, 5, 16'($urandom_range(16'h0080, 16'h01ff)));
					wf(1, 4, 16'h0014);
					wf(1, 0, 16'h0006);
					wf(0, 0, 16'h0002);
				end
			endcase
			for (int i = 0; i < 24; i++) begin
				n = $urandom_range(0, 3);
				p = eff(n / 2, n % 2) + $urandom_range(0, 16'h0600) - 32'h00000300;
				settle((i % 4 == 0) ? 16'($urandom) : p[15:0]);
			end
			$display("test relay round %0d done", r);
		end
		wf(0, 0, 16'h0003);
		wf(0, 1, 16'h1000);
		wf(0, 2, 16'h8000);
		wf(0, 3, 16'h0014);
		host.press(0, 1'b1);
		repeat (3) @(posedge clock);
		chk(symbolBlink[0], 1, "blink");
		chk(analogValue, 16'h1000, "shown");
		repeat (SHOW - 6) @(posedge clock);
		chk(analogValue, 16'h1000, "still shown");
		acc(1'b1, 8'h0c, 16'h0000);
		chk(q, 16'h000a, "hys restore");
		repeat (20) @(posedge clock);
		host.press(0, 1'b0);
		repeat (2) @(posedge clock);
		v1 = analogValue;
		chk(v1 > 16'h1000 && v1[7:0] == 8'h00, 1, "coarse up");
		host.press(0, 1'b1);
		repeat (14) @(posedge clock);
		host.press(0, 1'b0);
		repeat (2) @(posedge clock);
		v2 = analogValue;
		chk(v2 > v1 && v2 - v1 < 16'h0100 && v2[3:0] == 4'h0, 1, "fine");
		repeat (10) @(posedge clock);
		host.press(0, 1'b1);
		repeat (14) @(posedge clock);
		host.press(0, 1'b0);
		repeat (2) @(posedge clock);
		v3 = analogValue;
		chk(v3 < v2, 1, "reverse");
		waitSave(0);
		chk(n >= SAVE - 6, 1, "save late enough");
		repeat (2) @(posedge clock);
		chk({symbolBlink[0], analogValue}, {1'b0, pressure}, "back to measuring");
		acc(1'b1, 8'h04, 16'h0000);
		chk(q, v3, "stored low");
		acc(1'b1, 8'h08, 16'h0000);
		chk(q, 16'h8000, "high kept");
		$display("test button edit done");
		host.press(1, 1'b1);
		repeat (3) @(posedge clock);
		chk(analogValue, cfgv[1][5], "relative shown");
		acc(1'b1, 8'h40, 16'h0000);
		chk(q[4:2], 3'b100, "status blink");
		repeat (SHOW + 12) @(posedge clock);
		host.press(1, 1'b0);
		waitSave(1);
		acc(1'b1, 8'h28, 16'h0000);
		chk(q, cfgv[1][2], "relative thr kept");
		acc(1'b1, 8'h30, 16'h0000);
		chk(q, 16'h0014, "relative hys kept");
		$display("test relative button done");
		host.press(2, 1'b1);
		host.press(2, 1'b0);
		n = 0;
		for (int i = 0; i < ZERO + 20; i++) begin
			@(posedge clock);
			if (zeroAdjustActive === 1'b1) n++;
		end
		chk(32'(n), 32'(ZERO), "zero length");
		$display("test zero done");
		pressure <= 16'h1234;
		atmPressure <= 16'h1000;
		repeat (2) @(posedge clock);
		acc(1'b1, 8'h48, 16'h0000);
		chk(q, 16'h1000, "atm raw");
		acc(1'b0, 8'h44, 16'h0001);
		atmPressure <= 16'h1100;
		repeat (2) @(posedge clock);
		acc(1'b1, 8'h48, 16'h0000);
		chk(q, 16'h1334, "atm corrected");
		$display("test atm adjust done");
		summarize();
	end
endmodule : spr_setpoint_relay_tb
